// ===== verilog/spims_map.vh
`ifndef SPIMS_MAP_VH
`define SPIMS_MAP_VH
// ----------------------------------------
// Word format, divider and buffer depth
// ----------------------------------------
`define SPIMS_WORD_BITS 8
`define SPIMS_DIV_RESET 6'h01
`define SPIMS_DIV_UNIT 4
`define SPIMS_FIFO_DEPTH 8
// ----------------------------------------
// Sequencer states
// ----------------------------------------
`define SPIMS_ST_IDLE 2'h0
`define SPIMS_ST_SEL 2'h1
`define SPIMS_ST_SHIFT 2'h2
`define SPIMS_ST_DONE 2'h3
`endif

// ===== verilog/spims_master.v
// Behaviour
// RULE1: Port acts as bus master only
// RULE2: Eight-bit words exchanged full duplex
// RULE3: Drives clock and data out, reads data in
// RULE4: No collision detection, single master only
// RULE5: Clock pulses once per bit, idle otherwise
// RULE6: Change on one edge, sample opposite
// RULE7: Polarity selectable, phase fixed at one
// RULE8: First bit driven on first clock edge
// RULE9: Slave takes first edge as word start
// RULE10: Only one slave drives serial input
// RULE11: Unselected slave ignores clock, tristates output
// RULE12: Both shift registers form sixteen-bit ring
// RULE13: Polarity zero launches rising, samples falling
// RULE14: Bit order chosen, same both directions
// RULE15: Auto select low around each word
// RULE16: Clock divides by multiples of four
// RULE17: Completion pulse and received word output

`include "spims_map.vh"

// ----------------------------------------
// Transmit word buffer
// ----------------------------------------
module spims_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 8,
   parameter AW = 3
) (
   input wire mclk,
   input wire srst,
   input wire [WIDTH-1:0] in_data,
   input wire in_valid,
   output wire in_ready,
   output wire [WIDTH-1:0] out_data,
   output wire out_valid,
   input wire out_ready
);
   reg [WIDTH-1:0] mem [0:DEPTH-1]; // Word storage
   reg [AW-1:0] wr_q; // Write pointer
   reg [AW-1:0] rd_q; // Read pointer
   reg [AW:0] cnt_q; // Fill count
   reg ready_q; // Room for one more word, kept in a flop
   wire push;
   wire pop;

   assign in_ready = ready_q; // Straight from a flop, no gate after it
   assign out_valid = (cnt_q != 0);
   assign out_data = mem[rd_q];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   // Pointer and count update
   always @(posedge mclk) begin
      if (srst) begin
         wr_q <= {AW{1'b0}};
         rd_q <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
         ready_q <= 1'b1;
      end else begin
         if (push) begin
            mem[wr_q] <= in_data;
            wr_q <= (wr_q == DEPTH - 1) ? {AW{1'b0}} : wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= (rd_q == DEPTH - 1) ? {AW{1'b0}} : rd_q + 1'b1;
         end
         if (push && !pop) begin
            cnt_q <= cnt_q + 1'b1;
            // Full once this push takes the last slot
            ready_q <= (cnt_q != DEPTH - 1);
         end else if (pop && !push) begin
            cnt_q <= cnt_q - 1'b1;
            ready_q <= 1'b1;
         end
      end
   end
endmodule

// ----------------------------------------
// Master-only serial port core
// ----------------------------------------
module spims_master #(
   parameter WORD_BITS = `SPIMS_WORD_BITS,
   parameter FIFO_DEPTH = `SPIMS_FIFO_DEPTH
) (
   input wire mclk,
   input wire srst,
   input wire port_enable,
   input wire clock_polarity_select,
   input wire lsb_first_select,
   input wire auto_select_enable,
   input wire [5:0] clock_divider_setting,
   input wire [WORD_BITS-1:0] tx_data,
   input wire tx_valid,
   output wire tx_ready,
   output reg [WORD_BITS-1:0] rx_data_q,
   output reg rx_done_q,
   output reg busy_q,
   input wire serial_in_line,
   output reg serial_out_line,
   output reg serial_clock_out,
   output reg slave_select_out
);
   reg [1:0] state_q; // Sequencer state
   reg [7:0] div_cnt_q; // Half-period counter
   reg [3:0] bit_cnt_q; // Bits done
   reg phase_q; // First half of bit period, clock away from idle level
   reg [WORD_BITS-1:0] tx_sh_q; // Outgoing word
   reg [WORD_BITS-1:0] rx_sh_q; // Incoming word
   reg rx_s1_q; // Input synchroniser stage one
   reg rx_s2_q; // Input synchroniser stage two
   reg lsb_q; // Bit order latched per word
   reg cpol_q; // Polarity latched per word
   reg sel_q; // Auto select latched per word
   wire [7:0] half_div;
   wire [WORD_BITS-1:0] fifo_data;
   wire fifo_valid;
   wire fifo_take;
   wire half_tick;
   wire samp_now; // Return edge of a bit period
   reg [1:0] samp_q; // Return-edge strobes in flight

   // Shift one received bit in, in the chosen order
   function [WORD_BITS-1:0] shift_in;
      input [WORD_BITS-1:0] sh;
      input b;
      input lsb;
      begin
         shift_in = lsb ? {b, sh[WORD_BITS-1:1]} : {sh[WORD_BITS-2:0], b};
      end
   endfunction

   // Divisor is four times the setting; zero treated as one
   assign half_div = (clock_divider_setting == 6'h00) ? 8'd2 : {1'b0, clock_divider_setting, 1'b0}; // RULE16
   assign half_tick = (div_cnt_q == half_div - 8'd1);
   assign fifo_take = (state_q == `SPIMS_ST_IDLE) & fifo_valid & port_enable;
   // Sample point of the slave bit, on the edge back to idle level
   assign samp_now = (state_q == `SPIMS_ST_SHIFT) & half_tick & phase_q; // RULE6

   spims_fifo #(
      .WIDTH(WORD_BITS),
      .DEPTH(FIFO_DEPTH),
      .AW(3)
   ) u_fifo (
      .mclk(mclk),
      .srst(srst),
      .in_data(tx_data),
      .in_valid(tx_valid),
      .in_ready(tx_ready),
      .out_data(fifo_data),
      .out_valid(fifo_valid),
      .out_ready(fifo_take)
   );

   // Serial input synchroniser
   always @(posedge mclk) begin
      if (srst) begin
         rx_s1_q <= 1'b0;
         rx_s2_q <= 1'b0;
      end else begin
         rx_s1_q <= serial_in_line;
         rx_s2_q <= rx_s1_q;
      end
   end

   // Word sequencer: master only, no collision logic
   always @(posedge mclk) begin
      if (srst) begin
         state_q <= `SPIMS_ST_IDLE;
         div_cnt_q <= 8'h00;
         bit_cnt_q <= 4'h0;
         phase_q <= 1'b0;
         tx_sh_q <= {WORD_BITS{1'b0}};
         rx_sh_q <= {WORD_BITS{1'b0}};
         samp_q <= 2'h0;
         rx_data_q <= {WORD_BITS{1'b0}};
         rx_done_q <= 1'b0;
         busy_q <= 1'b0;
         lsb_q <= 1'b0;
         cpol_q <= 1'b0;
         sel_q <= 1'b0;
         serial_out_line <= 1'b0;
         serial_clock_out <= 1'b0;
         slave_select_out <= 1'b1;
      end else begin
         rx_done_q <= 1'b0;
         // Strobe waits out the synchroniser, so the pin level at the return edge is kept
         samp_q <= {samp_q[0], samp_now};
         if (samp_q[1]) begin
            rx_sh_q <= shift_in(rx_sh_q, rx_s2_q, lsb_q); // RULE2 RULE12 RULE14
         end
         case (state_q)
            `SPIMS_ST_IDLE: begin
               serial_clock_out <= clock_polarity_select; // RULE5
               slave_select_out <= 1'b1; // RULE15
               busy_q <= 1'b0;
               div_cnt_q <= 8'h00;
               if (fifo_take) begin // RULE1 RULE4
                  tx_sh_q <= fifo_data;
                  lsb_q <= lsb_first_select;
                  cpol_q <= clock_polarity_select;
                  sel_q <= auto_select_enable;
                  busy_q <= 1'b1;
                  slave_select_out <= ~auto_select_enable; // RULE15
                  state_q <= `SPIMS_ST_SEL;
               end
            end
            `SPIMS_ST_SEL: begin
               // One half period of select setup before first edge
               div_cnt_q <= half_tick ? 8'h00 : div_cnt_q + 8'd1;
               if (half_tick) begin
                  // First edge launches first bit
                  serial_clock_out <= ~cpol_q; // RULE8 RULE7 RULE13
                  serial_out_line <= lsb_q ? tx_sh_q[0] : tx_sh_q[WORD_BITS-1]; // RULE14 RULE3
                  phase_q <= 1'b1;
                  bit_cnt_q <= 4'h0;
                  state_q <= `SPIMS_ST_SHIFT;
               end
            end
            `SPIMS_ST_SHIFT: begin
               div_cnt_q <= half_tick ? 8'h00 : div_cnt_q + 8'd1;
               if (half_tick) begin
                  serial_clock_out <= ~serial_clock_out; // RULE5
                  if (phase_q) begin
                     // Opposite edge: sample strobe queued, next outgoing bit moved up
                     if (lsb_q) begin // RULE14
                        tx_sh_q <= {1'b0, tx_sh_q[WORD_BITS-1:1]};
                     end else begin
                        tx_sh_q <= {tx_sh_q[WORD_BITS-2:0], 1'b0}; // RULE2
                     end
                     bit_cnt_q <= bit_cnt_q + 4'd1;
                     phase_q <= 1'b0;
                     if (bit_cnt_q == WORD_BITS - 1) begin
                        state_q <= `SPIMS_ST_DONE;
                     end
                  end else begin
                     // Launch edge drives next bit
                     serial_out_line <= lsb_q ? tx_sh_q[0] : tx_sh_q[WORD_BITS-1]; // RULE6
                     phase_q <= 1'b1;
                  end
               end
            end
            `SPIMS_ST_DONE: begin
               // Clock back at idle level; hold select one half period
               div_cnt_q <= half_tick ? 8'h00 : div_cnt_q + 8'd1;
               if (half_tick) begin
                  slave_select_out <= 1'b1; // RULE15
                  // Last strobe may land on this very edge at the fastest divider
                  rx_data_q <= samp_q[1] ? shift_in(rx_sh_q, rx_s2_q, lsb_q) : rx_sh_q; // RULE17
                  rx_done_q <= 1'b1; // RULE17
                  busy_q <= 1'b0;
                  state_q <= `SPIMS_ST_IDLE;
               end
            end
            default: begin
               state_q <= `SPIMS_ST_IDLE;
            end
         endcase
      end
   end
endmodule

// ===== tb/spims_checker.sv
module spims_checker (
   input wire logic mclk,
   input wire logic srst,
   input wire logic clock_polarity_select,
   input wire logic auto_select_enable,
   input wire logic [5:0] clock_divider_setting,
   input wire logic rx_done_q,
   input wire logic busy_q,
   input wire logic serial_out_line,
   input wire logic serial_clock_out,
   input wire logic slave_select_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic sck_last_q = 1'b0; // Clock level one edge ago
   logic [4:0] edge_cnt_q = 5'h00; // Clock edges in this word
   // Count serial clock edges while a word is in flight
   always @(posedge mclk) begin
      sck_last_q <= serial_clock_out;
      if (srst || !busy_q) begin
         edge_cnt_q <= 5'h00;
      end else if (serial_clock_out != sck_last_q) begin
         edge_cnt_q <= edge_cnt_q + 5'h01;
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (srst);
   a_done_single:
   assert property (rx_done_q |=> !rx_done_q) else $error("done pulse too long");
   a_done_in_word:
   assert property (rx_done_q |-> $past(busy_q)) else $error("done outside word");
   a_word_bound:
   assert property ($rose(busy_q) |-> ##[30:300] rx_done_q) else $error("word not finished");
   a_clk_idle_level:
   assert property (!busy_q && !$past(busy_q) && $stable(clock_polarity_select)
      |-> serial_clock_out == clock_polarity_select) else $error("clock not idle");
   a_sel_idle_high:
   assert property (!busy_q && !$past(busy_q) |-> slave_select_out) else $error("select low idle");
   a_sel_at_start:
   assert property ($rose(busy_q) && $stable(auto_select_enable)
      |-> slave_select_out == !auto_select_enable) else $error("select wrong at start");
   a_half_period:
   assert property (clock_divider_setting == 6'h02 && busy_q && $changed(serial_clock_out)
      |=> $stable(serial_clock_out)[*3]) else $error("half period short");
   a_out_on_launch:
   assert property (busy_q && $past(busy_q) && $changed(serial_out_line)
      |-> $changed(serial_clock_out) && serial_clock_out != clock_polarity_select)
      else $error("data moved off launch edge");
   a_pulse_count:
   assert property (rx_done_q |-> edge_cnt_q == 5'h10) else $error("clock pulse count wrong");
endmodule
bind spims_master spims_checker spims_checker_i (.mclk(mclk), .srst(srst),
   .clock_polarity_select(clock_polarity_select), .auto_select_enable(auto_select_enable),
   .clock_divider_setting(clock_divider_setting), .rx_done_q(rx_done_q), .busy_q(busy_q),
   .serial_out_line(serial_out_line), .serial_clock_out(serial_clock_out),
   .slave_select_out(slave_select_out));

// ===== tb/spims_slave.sv
// Slave shift register on the far side of the port
module spims_slave (
   input wire logic mclk,
   input wire logic sck,
   input wire logic mosi,
   input wire logic ssn,
   input wire logic cpol,
   input wire logic lsb,
   output logic miso
);
   timeunit 1ns;
   timeprecision 1ps;
   logic sck_q = 1'b0; // Last clock level seen
   logic [7:0] sh = 8'h5a; // Half of the ring
   logic pin_q = 1'b0; // Level shown on the pin
   assign miso = pin_q;
   // Launch on edge away from idle, capture on return
   always @(posedge mclk) begin
      sck_q <= sck;
      if (ssn) begin
         pin_q <= ~pin_q;
      end else if (sck != sck_q && sck != cpol) begin
         pin_q <= lsb ? sh[0] : sh[7];
      end else if (sck != sck_q) begin
         sh <= lsb ? {mosi, sh[7:1]} : {sh[6:0], mosi};
      end
   end
endmodule

// ===== tb/spims_master_tb.sv
module spims_master_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 0, srst = 1, en = 0, pol = 0, lsb = 0, auto_s = 1, tx_valid = 0, bad;
   logic [5:0] div = 6'h02;
   logic [7:0] tx_data = 8'h00, exp_sh = 8'h5a, d;
   logic [7:0] q[$];
   wire tx_ready, rx_done_q, busy_q, mosi, sck, ssn, miso;
   wire [7:0] rx_data_q;
   int err_total = 0, n_tests = 0;
   always #12.5 mclk = ~mclk;
   spims_master spims_master_i (.mclk(mclk), .srst(srst), .port_enable(en), .clock_polarity_select(pol),
      .lsb_first_select(lsb), .auto_select_enable(auto_s), .clock_divider_setting(div), .tx_data(tx_data),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data_q(rx_data_q), .rx_done_q(rx_done_q),
      .busy_q(busy_q), .serial_in_line(miso), .serial_out_line(mosi), .serial_clock_out(sck),
      .slave_select_out(ssn));
   spims_slave spims_slave_i (.mclk(mclk), .sck(sck), .mosi(mosi), .ssn(ssn), .cpol(pol), .lsb(lsb),
      .miso(miso));
   task chk(string nm, logic [7:0] seen, logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task push(logic [7:0] v);
      @(negedge mclk);
      tx_data = v;
      tx_valid = 1;
      @(negedge mclk);
      tx_valid = 0;
   endtask
   // Wait for one word, then check both halves of the ring, or that select stayed high when off
   task take(logic [7:0] v, logic on);
      int k;
      k = 0;
      bad = 0;
      while (rx_done_q !== 1'b1 && k < 500) begin
         @(negedge mclk);
         bad = bad | (!on && ssn !== 1'b1);
         k++;
      end
      chk("word done", {7'h0, rx_done_q}, 8'h01);
      if (on) begin
         chk("rx word", rx_data_q, exp_sh);
         chk("slave word", spims_slave_i.sh, v);
         exp_sh = v;
      end else chk("select off", {7'h0, bad}, 8'h00);
      @(negedge mclk);
   endtask
   task close_out;
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      #500000;
      err_total++;
      close_out;
   end
   initial begin
      void'($urandom(32'heb97));
      repeat (4) @(negedge mclk);
      srst = 0;
      en = 1;
      // Random modes, divider 0, 1 and 2, one word without select
      for (int i = 0; i < 12; i++) begin
         @(negedge mclk);
         pol = $urandom;
         lsb = $urandom;
         auto_s = (i != 5);
         div = 6'(i % 3);
         d = $urandom;
         push(d);
         take(d, auto_s);
         $display("word test %0d done", i);
      end
      // Fill the buffer while held, then drain back to back
      en = 0;
      for (int i = 0; i < 8; i++) begin
         d = $urandom;
         q.push_back(d);
         push(d);
      end
      chk("tx ready full", {7'h0, tx_ready}, 8'h00);
      en = 1;
      foreach (q[j]) take(q[j], 1'b1);
      $display("buffer test done");
      close_out;
   end
endmodule
